// ===== rtl/keypad_scan.sv
// keypad scanner: registers, debounce and scan timing, key detect
`timescale 1ns/10ps
module keypad_scan #(
    parameter int unsigned TICK_CYCLES = keypad_pkg::KCLK_CYCLES
) (
    input  wire logic                             ref_clk,
    input  wire logic                             rst,
    input  wire logic                             ce,
    input  wire logic [keypad_pkg::ADDR_W-1:0]    addr,
    input  wire logic [keypad_pkg::DATA_W-1:0]    wdata,
    input  wire logic                             wr,
    input  wire logic                             rd,
    output logic      [keypad_pkg::DATA_W-1:0]    rdata,
    input  wire logic [keypad_pkg::ROWS_N-1:0]    row_in,
    output logic      [keypad_pkg::COLS_N-1:0]    col_out,
    input  wire logic                             keypad_clk_en,
    output logic                                  irq
);
    import keypad_pkg::*;

    typedef enum logic [4:0] {
        ST_IDLE     = 5'h01,
        ST_PRESS_DB = 5'h02,
        ST_SCAN     = 5'h04,
        ST_RELEASE  = 5'h08,
        ST_REL_DB   = 5'h10
    } scan_state_t;

    // ======================================================
    // pins and keypad clock
    logic [ROWS_N-1:0] rows_s;
    tick_if            kt ();

    row_sync #(.W(ROWS_N)) u_sync (
        .ref_clk (ref_clk),
        .rst     (rst),
        .ce      (ce),
        .d       (row_in),
        .q       (rows_s)
    );

    keypad_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
        .ref_clk (ref_clk),
        .rst     (rst),
        .ce      (ce),
        .clk_en  (keypad_clk_en),
        .t       (kt.src)
    );

    // ======================================================
    // state
    scan_state_t       state_q;
    logic [8:0]        cnt_q;
    logic [2:0]        col_idx_q;
    logic [ROWS_N-1:0] hit_row_q;
    logic [2:0]        hit_col_q;
    logic [1:0]        hit_n_q;
    logic [COLS_N-1:0] col_reg_q;
    logic [COLS_N-1:0] col_out_q;
    logic [ROWS_N-1:0] row_q;
    logic [7:0]        timing_q;
    logic              auto_en_q;
    logic              flag_q;
    logic              irq_en_q;
    logic              prev_high_q;
    logic [1:0]        evt_q;
    logic [1:0]        evt_mask_q;
    logic [7:0]        rdata_q;

    logic              any_low;
    logic              all_high;
    logic [ROWS_N-1:0] rows_low;
    logic              row_single;
    logic [5:0]        db_code;
    logic [1:0]        sc_code;
    logic [8:0]        db_target;
    logic [8:0]        sc_target;
    logic              db_done;
    logic              sc_done;
    logic              scan_last;
    logic [1:0]        hit_n_nx;
    logic [ROWS_N-1:0] hit_row_nx;
    logic [2:0]        hit_col_nx;
    logic              scan_end;
    logic              valid_done;
    logic              set_auto;
    logic              set_byp;
    logic              rel_done;
    logic              rd_stat;
    logic [7:0]        status_rd;

    assign rows_low   = ~rows_s;
    assign any_low    = |rows_low;
    assign all_high   = &rows_s;
    assign row_single = any_low &&
                        ((rows_low & (rows_low - ROWS_N'(1))) == '0);

    // ======================================================
    // interval targets in keypad ticks
    assign db_code   = timing_q[DB_MSB:DB_LSB];
    assign sc_code   = timing_q[SC_MSB:SC_LSB];
    assign db_target = (db_code == 6'h00) ? 9'(DB_ZERO_STEPS * DB_STEP_MS)
                     : 9'(db_code) * 9'(DB_STEP_MS);
    assign sc_target = (sc_code == 2'h0) ? 9'(SCAN_ZERO_MS)
                     : 9'(sc_code);
    assign db_done   = kt.tick && (cnt_q + 9'h001 >= db_target);
    assign sc_done   = kt.tick && (cnt_q + 9'h001 >= sc_target);
    assign scan_last = col_idx_q == 3'(COLS_N - 1);

    // column check result; several low rows or hits make it invalid
    always_comb begin
        hit_n_nx   = hit_n_q;
        hit_row_nx = hit_row_q;
        hit_col_nx = hit_col_q;
        if (any_low) begin
            hit_n_nx   = (hit_n_q == 2'h0 && row_single) ? 2'h1 : 2'h2;
            hit_row_nx = rows_s;
            hit_col_nx = col_idx_q;
        end
    end

    assign scan_end   = state_q == ST_SCAN && sc_done && scan_last;
    assign valid_done = scan_end && hit_n_nx == 2'h1;
    assign set_auto   = auto_en_q && valid_done;
    assign set_byp    = !auto_en_q && prev_high_q
                        && !all_high;
    assign rel_done   = state_q == ST_REL_DB && db_done && all_high;
    assign rd_stat    = rd && addr == OFF_STATUS;

    // ======================================================
    // scan sequencer
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_q   <= ST_IDLE;
            cnt_q     <= 9'h000;
            col_idx_q <= 3'h0;
            hit_n_q   <= 2'h0;
            hit_row_q <= RST_ROW;
            hit_col_q <= 3'h0;
        end else if (ce) begin
            if (!auto_en_q) begin
                state_q <= ST_IDLE;
                cnt_q   <= 9'h000;
            end else begin
                case (state_q)
                    ST_IDLE: begin
                        cnt_q <= 9'h000;
                        if (any_low) begin
                            state_q <= ST_PRESS_DB;
                        end
                    end
                    ST_PRESS_DB: begin
                        if (kt.tick) begin
                            cnt_q <= cnt_q + 9'h001;
                        end
                        if (db_done) begin
                            cnt_q     <= 9'h000;
                            col_idx_q <= 3'h0;
                            hit_n_q   <= 2'h0;
                            state_q   <= any_low ? ST_SCAN : ST_IDLE;
                        end
                    end
                    ST_SCAN: begin
                        if (kt.tick) begin
                            cnt_q <= cnt_q + 9'h001;
                        end
                        if (sc_done) begin
                            cnt_q     <= 9'h000;
                            hit_n_q   <= hit_n_nx;
                            hit_row_q <= hit_row_nx;
                            hit_col_q <= hit_col_nx;
                            col_idx_q <= col_idx_q + 3'h1;
                            if (scan_last) begin
                                state_q <= ST_RELEASE;
                            end
                        end
                    end
                    ST_RELEASE: begin
                        cnt_q <= 9'h000;
                        if (all_high) begin
                            state_q <= ST_REL_DB;
                        end
                    end
                    ST_REL_DB: begin
                        if (kt.tick) begin
                            cnt_q <= cnt_q + 9'h001;
                        end
                        if (any_low) begin
                            cnt_q <= 9'h000;
                        end else if (db_done) begin
                            state_q <= ST_IDLE;
                        end
                    end
                    default: begin
                        state_q <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // ======================================================
    // column drive
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            col_out_q <= RST_COL;
        end else if (ce) begin
            if (!auto_en_q) begin
                col_out_q <= col_reg_q;
            end else if (state_q == ST_SCAN) begin
                col_out_q <= ~(COLS_N'(1) << col_idx_q);
            end else begin
                col_out_q <= '0;
            end
        end
    end

    // ======================================================
    // key location registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            col_reg_q <= RST_COL;
            row_q     <= RST_ROW;
        end else if (ce) begin
            if (set_auto) begin
                row_q     <= hit_row_nx;
                col_reg_q <= ~(COLS_N'(1) << hit_col_nx);
            end else if (wr && addr == OFF_COL) begin
                col_reg_q <= wdata[COLS_N-1:0];
            end
        end
    end

    // ======================================================
    // control, key detect flag and events
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            timing_q    <= RST_TIMING;
            auto_en_q   <= 1'b0;
            irq_en_q    <= 1'b0;
            evt_mask_q  <= 2'h0;
        end else if (ce && wr) begin
            if (addr == OFF_TIMING) begin
                timing_q <= wdata;
            end else if (addr == OFF_STATUS) begin
                auto_en_q <= wdata[STAT_AUTO];
                irq_en_q  <= wdata[STAT_IRQEN];
            end else if (addr == OFF_EVT_MASK) begin
                evt_mask_q <= wdata[1:0];
            end
        end
    end

    // set wins over the clearing read or write
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            flag_q      <= 1'b0;
            prev_high_q <= 1'b1;
            evt_q       <= 2'h0;
        end else if (ce) begin
            prev_high_q <= all_high;
            if (set_auto || set_byp) begin
                flag_q <= 1'b1;
            end else if (rd_stat) begin
                flag_q <= 1'b0;
            end
            for (int i = 0; i < 2; i++) begin
                if (wr && addr == OFF_EVT && wdata[i]) begin
                    evt_q[i] <= 1'b0;
                end
            end
            if (set_auto || set_byp) begin
                evt_q[EVT_KEY] <= 1'b1;
            end
            if (rel_done) begin
                evt_q[EVT_REL] <= 1'b1;
            end
        end
    end

    // ======================================================
    // read back
    always_comb begin
        status_rd             = 8'h00;
        status_rd[STAT_KCLK]  = kt.level;
        status_rd[STAT_AUTO]  = auto_en_q;
        status_rd[STAT_FLAG]  = flag_q;
        status_rd[STAT_IRQEN] = irq_en_q;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdata_q <= 8'h00;
        end else if (ce) begin
            if (!rd) begin
                rdata_q <= 8'h00;
            end else if (addr == OFF_COL) begin
                rdata_q <= {3'h0, col_reg_q};
            end else if (addr == OFF_ROW) begin
                rdata_q <= {2'h0, auto_en_q ? row_q
                                            : rows_s};
            end else if (addr == OFF_TIMING) begin
                rdata_q <= timing_q;
            end else if (addr == OFF_STATUS) begin
                rdata_q <= status_rd;
            end else if (addr == OFF_EVT) begin
                rdata_q <= {6'h00, evt_q};
            end else if (addr == OFF_EVT_MASK) begin
                rdata_q <= {6'h00, evt_mask_q};
            end else begin
                rdata_q <= 8'h00;
            end
        end
    end

    assign rdata   = rdata_q;
    assign col_out = col_out_q;
    assign irq     = (flag_q && irq_en_q) || |(evt_q & evt_mask_q);

    // ======================================================
    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    key_store_a: assert property (
        ce && set_auto |=> row_q == $past(hit_row_nx) && flag_q)
        else $error("valid key row not stored");
    row_read_a: assert property (
        ce && rd && addr == OFF_ROW && auto_en_q
        |=> rdata == {2'h0, $past(row_q)})
        else $error("row register readback wrong");
    db_len_a: assert property (
        state_q == ST_PRESS_DB && auto_en_q && kt.tick
        && cnt_q + 9'h001 < db_target && ce |=> state_q == ST_PRESS_DB)
        else $error("press debounce ended early");
    scan_len_a: assert property (
        ce && state_q == ST_SCAN && auto_en_q && !sc_done
        |=> col_idx_q == $past(col_idx_q))
        else $error("column advanced before scan interval");
    kclk_read_a: assert property (
        ce && rd_stat |=> rdata[STAT_KCLK] == $past(kt.level))
        else $error("keypad clock level not readable");
    bypass_cols_a: assert property (
        ce && !auto_en_q |=> col_out == $past(col_reg_q))
        else $error("bypass columns not from column register");
    byp_edge_a: assert property (
        ce && !auto_en_q && prev_high_q && !all_high |=> flag_q)
        else $error("bypass row edge missed");
    read_clear_a: assert property (
        ce && rd_stat && !set_auto && !set_byp |=> !flag_q)
        else $error("status read did not clear key detect");
    irq_gate_a: assert property (
        !irq_en_q && (evt_q & evt_mask_q) == 2'h0 |-> !irq)
        else $error("interrupt raised with gate off");
    idle_cols_a: assert property (
        ce && auto_en_q && state_q == ST_IDLE |=> col_out == '0)
        else $error("idle columns not all low");
    multi_key_a: assert property (
        ce && scan_end && hit_n_nx != 2'h1
        |=> row_q == $past(row_q) && state_q == ST_RELEASE)
        else $error("invalid scan reported a key");
    rel_bounce_a: assert property (
        ce && auto_en_q && state_q == ST_REL_DB && any_low
        |=> state_q == ST_REL_DB && cnt_q == 9'h000)
        else $error("release debounce not restarted");

    valid_key_c: cover property (ce && set_auto);
    bypass_edge_c: cover property (ce && set_byp);
    release_done_c: cover property (ce && rel_done);
    multi_key_c: cover property (ce && scan_end && hit_n_nx == 2'h2);
endmodule

// ===== include/keypad_pkg.sv
// register map, field layout and timing constants of the keypad scanner
package keypad_pkg;
    // ======================================================
    // bus and matrix size
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int ROWS_N = 6;
    localparam int COLS_N = 5;
    // ======================================================
    // register offsets
    localparam logic [7:0] OFF_COL      = 8'hD1;
    localparam logic [7:0] OFF_ROW      = 8'hD2;
    localparam logic [7:0] OFF_TIMING   = 8'hD3;
    localparam logic [7:0] OFF_STATUS   = 8'hD4;
    localparam logic [7:0] OFF_EVT      = 8'hD8;
    localparam logic [7:0] OFF_EVT_MASK = 8'hD9;
    // ======================================================
    // reset values
    localparam logic [4:0] RST_COL    = 5'h1F;
    localparam logic [5:0] RST_ROW    = 6'h3F;
    localparam logic [7:0] RST_TIMING = 8'h00;
    // ======================================================
    // field positions
    localparam int DB_LSB     = 2;
    localparam int DB_MSB     = 7;
    localparam int SC_LSB     = 0;
    localparam int SC_MSB     = 1;
    localparam int STAT_KCLK  = 3;
    localparam int STAT_AUTO  = 2;
    localparam int STAT_FLAG  = 1;
    localparam int STAT_IRQEN = 0;
    localparam int EVT_KEY    = 0;
    localparam int EVT_REL    = 1;
    // ======================================================
    // timing
    localparam int REF_CLK_NS     = 20;
    localparam int KCLK_PERIOD_NS = 1000000;
    localparam int KCLK_CYCLES    = KCLK_PERIOD_NS / REF_CLK_NS;
    localparam int DB_STEP_MS     = 4;
    localparam int DB_ZERO_STEPS  = 64;
    localparam int SCAN_ZERO_MS   = 4;
endpackage

// ===== include/tick_if.sv
// keypad clock tick and level carried from the divider to the scanner
`timescale 1ns/10ps
interface tick_if;
    logic tick;
    logic level;
    modport src (output tick, output level);
    modport dst (input tick, input level);
endinterface

// ===== rtl/row_sync.sv
// two-flop synchroniser for the sense row pins
`timescale 1ns/10ps
module row_sync #(
    parameter int W = 6
) (
    input  wire logic         ref_clk,
    input  wire logic         rst,
    input  wire logic         ce,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;

    // rows idle high through the pull-ups
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
                s1_q[i] <= 1'b1;
                s2_q[i] <= 1'b1;
            end else if (ce) begin
                s1_q[i] <= d[i];
                s2_q[i] <= s1_q[i];
            end
        end
    end

    assign q = s2_q;
endmodule

// ===== rtl/keypad_tick.sv
// divider making the 1 ms keypad tick and keypad clock level
`timescale 1ns/10ps
module keypad_tick #(
    parameter int unsigned TICK_CYCLES = keypad_pkg::KCLK_CYCLES
) (
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic ce,
    input  wire logic clk_en,
    tick_if.src       t
);
    // TICK_CYCLES must be at least 2
    localparam int CW = $clog2(TICK_CYCLES);
    localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);
    localparam logic [CW-1:0] HALF = CW'(TICK_CYCLES / 2);

    logic [CW-1:0] cnt_q;
    logic          tick_q;
    logic          level_q;

    // stopped clock holds its level and gives no tick
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt_q   <= '0;
            tick_q  <= 1'b0;
            level_q <= 1'b0;
        end else if (ce) begin
            tick_q <= clk_en && (cnt_q == LAST);
            if (clk_en) begin
                cnt_q   <= (cnt_q == LAST) ? '0 : cnt_q + CW'(1);
                level_q <= cnt_q >= HALF;
            end
        end
    end

    assign t.tick  = tick_q;
    assign t.level = level_q;
endmodule

// ===== bench/keypad_matrix.sv
// switch matrix model facing the scanner's column drives and sense rows
`timescale 1ns/10ps
module keypad_matrix (
    input  wire logic [keypad_pkg::COLS_N-1:0] col_out,
    input  wire logic [29:0]                   keys,
    output logic      [keypad_pkg::ROWS_N-1:0] row_in
);
    import keypad_pkg::*;
    // ======================================================
    // rows pulled up; a closed switch on a low column pulls its row low
    always_comb begin
        row_in = '1;
        for (int r = 0; r < ROWS_N; r++) begin
            for (int c = 0; c < COLS_N; c++) begin
                if (keys[r*COLS_N+c] && col_out[c] === 1'b0) begin
                    row_in[r] = 1'b0;
                end
            end
        end
    end
endmodule

// ===== bench/test_keypad_scan.sv
// self-checking bench of the keypad scanner
`timescale 1ns/10ps
module test_keypad_scan;
    import keypad_pkg::*;
    localparam int T = 8;
    logic        ref_clk;
    logic        rst;
    logic        wr;
    logic        rd;
    logic        clk_en;
    logic [7:0]  addr;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic [7:0]  v;
    logic [5:0]  row_in;
    logic [4:0]  col_out;
    logic        irq;
    logic [29:0] keys;
    logic [1:0]  lvl;
    int          n_errors;
    int          tests_run;
    int          cyc;

    keypad_scan #(.TICK_CYCLES(T)) dut (
        .ref_clk(ref_clk), .rst(rst), .ce(1'b1), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .row_in(row_in),
        .col_out(col_out), .keypad_clk_en(clk_en), .irq(irq));
    keypad_matrix pad (.col_out(col_out), .keys(keys), .row_in(row_in));

    // ======================================================
    // bus tasks and checks
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a);
        @(posedge ref_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask
    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic span(input string nm, input int lo, input int hi);
        tests_run++;
        if (cyc < lo || cyc > hi) begin
            n_errors++;
            $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, cyc);
            tally_and_finish();
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // one automatic press and release, timed against the programmed codes
    task automatic auto_key(input int db, input int sc, input int r,
                            input int c);
        int dt;
        int st;
        int n;
        dt = ((db == 0) ? 64 : db) * 4;
        st = (sc == 0) ? 4 : sc;
        n = dt + COLS_N * st;
        wr_reg(OFF_TIMING, {db[5:0], sc[1:0]});
        @(posedge ref_clk);
        keys[r*5+c] <= 1'b1;
        cyc = 0;
        while (irq !== 1'b1 && cyc < (n + 4) * T) begin
            @(posedge ref_clk);
            #1;
            cyc++;
        end
        span("press to irq", (n - 2) * T, (n + 2) * T + 8);
        rd_reg(OFF_ROW);
        chk("row reg", {2'b00, ~(6'h01 << r)}, v);
        rd_reg(OFF_COL);
        chk("col reg", {3'b000, ~(5'h01 << c)}, v);
        rd_reg(OFF_STATUS);
        chk("status", 8'h07, v & 8'hF7);
        chk("irq after read", 8'h00, {7'b0, irq});
        chk("col in release", 8'h00, {3'b000, col_out});
        keys <= '0;
        cyc = 0;
        v = 8'h00;
        while (v[1] !== 1'b1 && cyc < (dt + 3) * T) begin
            rd_reg(OFF_EVT);
            cyc += 2;
        end
        span("release debounce", (dt - 2) * T, (dt + 2) * T);
        wr_reg(OFF_EVT, 8'h03);
        rd_reg(OFF_EVT);
        chk("event clear", 8'h00, v);
        chk("col idle", 8'h00, {3'b000, col_out});
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    initial begin
        rst = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        clk_en = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        keys = '0;
        n_errors = 0;
        tests_run = 0;
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        // ======================================================
        // reset values, read-only bits, unmapped address
        rd_reg(OFF_ROW);
        chk("row reset", 8'h3F, v);
        rd_reg(OFF_TIMING);
        chk("timing reset", 8'h00, v);
        rd_reg(OFF_STATUS);
        chk("status reset", 8'h00, v);
        rd_reg(8'hE0);
        chk("unmapped", 8'h00, v);
        wr_reg(OFF_STATUS, 8'h0A);
        rd_reg(OFF_STATUS);
        chk("status ro bits", 8'h00, v);
        wr_reg(OFF_TIMING, 8'hA6);
        rd_reg(OFF_TIMING);
        chk("timing rw", 8'hA6, v);
        // ======================================================
        // bypass with keypad clock stopped
        wr_reg(OFF_COL, 8'h1E);
        idle(2);
        chk("col follows reg", 8'h1E, {3'b000, col_out});
        wr_reg(OFF_COL, 8'h00);
        for (int r = 0; r < 6; r++) begin
            keys[r*5+(r%5)] <= 1'b1;
            idle(5);
            rd_reg(OFF_ROW);
            chk("live row", {2'b00, ~(6'h01 << r)}, v);
            chk("irq gated", 8'h00, {7'b0, irq});
            rd_reg(OFF_STATUS);
            chk("bypass flag", 8'h02, v);
            rd_reg(OFF_STATUS);
            chk("flag read clear", 8'h00, v);
            keys <= '0;
            idle(5);
        end
        wr_reg(OFF_STATUS, 8'h01);
        keys[7] <= 1'b1;
        idle(5);
        chk("bypass irq", 8'h01, {7'b0, irq});
        rd_reg(OFF_STATUS);
        chk("flag with gate", 8'h03, v);
        chk("irq cleared", 8'h00, {7'b0, irq});
        keys <= '0;
        idle(5);
        // ======================================================
        // automatic scanning over every scan code
        clk_en <= 1'b1;
        wr_reg(OFF_STATUS, 8'h05);
        lvl = 2'b00;
        for (int i = 0; i < 12; i++) begin
            rd_reg(OFF_STATUS);
            lvl[v[3]] = 1'b1;
        end
        chk("clock level moves", 8'h03, {6'b0, lvl});
        auto_key(1, 1, 0, 0);
        auto_key(2, 2, 5, 4);
        auto_key(1, 3, 3, 2);
        auto_key(0, 0, 4, 3);
        // two keys in one column report no key, only the release event
        wr_reg(OFF_TIMING, 8'h05);
        keys[6] <= 1'b1;
        keys[16] <= 1'b1;
        idle(12 * T);
        rd_reg(OFF_STATUS);
        chk("double key", 8'h05, v & 8'hF7);
        rd_reg(OFF_ROW);
        chk("row kept", 8'h2F, v);
        keys <= '0;
        idle(80 * T);
        rd_reg(OFF_EVT);
        chk("invalid release", 8'h02, v);
        wr_reg(OFF_STATUS, 8'h00);
        idle(2);
        chk("abort to col reg", 8'h17, {3'b000, col_out});
        tally_and_finish();
    end
endmodule
